//--- iefl_pkg.sv
// Shared constants and types of the interrupt enable and flag logic.
package iefl_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the Avalon-MM slave
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_ENABLE_TWO = 5'h00;
    localparam logic [4:0] ADDR_FLAG_ONE   = 5'h04;
    localparam logic [4:0] ADDR_SYS_CTRL   = 5'h08;
    localparam logic [4:0] ADDR_STATUS     = 5'h0c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         TMR_EN_BIT  = 5;
    localparam logic [7:0] EN2_ONES    = 8'h1f;
    localparam logic       TMR_EN_RST  = 1'b0;
    localparam int         DT_FLAG_BIT = 7;
    localparam int         RTC_BIT     = 6;
    localparam logic [7:0] FLAG_MASK   = 8'hcf;
    localparam logic [7:0] FLAG_RESET  = 8'h00;
    localparam int         DT_ON_BIT   = 7;
    localparam logic [7:0] SYSC_MASK   = 8'hcf;
    localparam logic [7:0] SYSC_RESET  = 8'h00;
    localparam int         STAT_VEC_LSB = 8;

    // ------------------------------------------------------------------
    // Sources and vector numbers, lowest number wins
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 8;
    localparam int SRC_DT  = 4;
    localparam int SRC_RTC = 5;
    localparam int SRC_TMR = 6;
    localparam int SRC_SCI = 7;
    localparam logic [NUM_SRC-1:0] EXT_SRC_MASK = 8'h0f;
    localparam logic [5:0] VEC_NONE     = 6'h3f;
    localparam logic [5:0] VEC_RESERVED = 6'h21;
    localparam logic [NUM_SRC-1:0][5:0] SRC_VEC = {
        6'h22, 6'h1d, 6'h15, 6'h0e, 6'h13, 6'h12, 6'h11, 6'h10};

    // ------------------------------------------------------------------
    // Sequence lengths in states, one state per core_clk cycle
    // ------------------------------------------------------------------
    localparam logic [4:0] PRIO_EXT_STATES = 5'h02;
    localparam logic [4:0] PRIO_INT_STATES = 5'h01;
    localparam logic [4:0] PHASE_STATES    = 5'h04;

    typedef enum logic [2:0] {
        S_IDLE, S_PRIO, S_WAIT, S_PUSH, S_VFETCH, S_IFETCH, S_INTERN
    } iefl_state_t;

endpackage : iefl_pkg

//--- iefl_prio.sv
// Priority selector: picks the pending source with the lowest vector.
`timescale 1ns/1ns
module iefl_prio (
    // Pending and enabled requests
    input  wire logic [iefl_pkg::NUM_SRC-1:0] req,
    // Winner
    output logic                              any_req,
    output logic [5:0]                        win_vec,
    output logic [iefl_pkg::NUM_SRC-1:0]      win_onehot
);
    import iefl_pkg::*;

    always_comb
    begin
        any_req    = 1'b0;
        win_vec    = VEC_NONE;
        win_onehot = '0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (req[i] && (SRC_VEC[i] < win_vec))
            begin
                any_req       = 1'b1;
                win_vec       = SRC_VEC[i];
                win_onehot    = '0;
                win_onehot[i] = 1'b1;
            end
        end
    end

endmodule : iefl_prio

//--- iefl_seq.sv
// State counter timing each step of the exception sequence.
`timescale 1ns/1ns
module iefl_seq (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       load,
    input  wire logic [4:0] count,
    // Last state of the step
    output logic            expired
);
    logic [4:0] remain;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            remain <= 5'h00;
        else if (load)
            remain <= count;
        else if (remain != 5'h00)
            remain <= remain - 5'h01;
    end

    assign expired = (remain == 5'h01);

endmodule : iefl_seq

//--- iefl_top.sv
// Interrupt enable and flag registers with exception sequencing.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
//
// Functional notes
// - Timer overflow enable resets zero, gates requests
// - Enable register top two bits read zero
// - Enable register low five bits read one
// - Cleared colliding request still taken after clear
// - Flag register holds transition, clock, pin flags
// - Sleep direct transition sets flag when enabled
// - Transition flag resets zero, cleared by zero-write
// - Priority: two states external, one internal
// - Wait instruction, then four-state sequence steps
// - Serial three shares vector 34, 33 reserved
module iefl_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt sources
    input  wire logic        timer_ovf_req,
    input  wire logic        rtc_evt,
    input  wire logic [3:0]  external_irq_pins,
    input  wire logic        sci3_rx_full,
    input  wire logic        sci3_tx_empty,
    input  wire logic        sci3_tx_end,
    input  wire logic        sci3_rx_err,
    input  wire logic        sleep_direct,
    // CPU core
    input  wire logic        mask_bit,
    input  wire logic        insn_done,
    output logic             timer_ovf_irq,
    output logic             exc_start,
    output logic             stack_push,
    output logic             vector_fetch,
    output logic             handler_fetch,
    output logic             internal_proc,
    output logic             exc_done,
    output logic      [5:0]  vector_no
);
    import iefl_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [4:0] a,
                                 input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic                 ack;
    logic                 acc;
    logic                 wr_commit;
    logic                 wr_en2;
    logic                 wr_flag;
    logic                 wr_sysc;
    logic [7:0]           wdat;
    logic [31:0]          read_val;
    logic                 tmr_en;
    logic [7:0]           irq_enable_two;
    logic [7:0]           irq_flag_one;
    logic [7:0]           system_control_two;
    logic [7:0]           flag_set;
    logic [7:0]           flag_clr;
    logic [NUM_SRC-1:0]   req;
    logic                 any_req;
    logic [5:0]           win_vec;
    logic [NUM_SRC-1:0]   win_onehot;
    logic                 win_ext;
    logic                 ext_lat;
    iefl_state_t          state;
    iefl_state_t          next_state;
    logic                 seq_load;
    logic [4:0]           seq_count;
    logic                 expired;

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the answer
    // ------------------------------------------------------------------
    assign acc             = avs_read | avs_write;
    assign avs_waitrequest = acc & ~ack;
    assign wdat            = avs_writedata[7:0];
    // Only lane 0 carries register data, so a write lacking it is void.
    assign wr_commit = avs_write & ack & avs_byteenable[0];
    assign wr_en2    = wr_commit & hit(avs_address, ADDR_ENABLE_TWO);
    assign wr_flag   = wr_commit & hit(avs_address, ADDR_FLAG_ONE);
    assign wr_sysc   = wr_commit & hit(avs_address, ADDR_SYS_CTRL);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            ack <= 1'b0;
        else
            ack <= acc & ~ack;
    end

    // The fixed bits are constants of the read path, never stored.
    assign irq_enable_two =
        EN2_ONES | ({7'h00, tmr_en} << TMR_EN_BIT);

    always_comb
    begin
        read_val = 32'h0000_0000;
        if (hit(avs_address, ADDR_ENABLE_TWO))
            read_val[7:0] = irq_enable_two;
        else if (hit(avs_address, ADDR_FLAG_ONE))
            read_val[7:0] = irq_flag_one;
        else if (hit(avs_address, ADDR_SYS_CTRL))
            read_val[7:0] = system_control_two;
        else if (hit(avs_address, ADDR_STATUS))
        begin
            read_val[2:0] = 3'(state);
            read_val[STAT_VEC_LSB +: 6] = vector_no;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            avs_readdata <= 32'h0000_0000;
        else if (acc && !ack)
            avs_readdata <= read_val;
    end

    // ------------------------------------------------------------------
    // Enable and control registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            tmr_en <= TMR_EN_RST;
        else if (wr_en2)
            tmr_en <= wdat[TMR_EN_BIT];
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            system_control_two <= SYSC_RESET;
        else if (wr_sysc)
            system_control_two <= wdat & SYSC_MASK;
    end

    assign timer_ovf_irq = timer_ovf_req & tmr_en;

    // ------------------------------------------------------------------
    // Flag register: hardware sets, a written zero clears, set wins
    // ------------------------------------------------------------------
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[3:0] = external_irq_pins;
        flag_set[RTC_BIT] = rtc_evt;
        flag_set[DT_FLAG_BIT] =
            sleep_direct & system_control_two[DT_ON_BIT];
        flag_clr = wr_flag ? ~wdat : 8'h00;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irq_flag_one <= FLAG_RESET;
        else
            irq_flag_one <= (flag_set | (irq_flag_one & ~flag_clr))
                            & FLAG_MASK;
    end

    // ------------------------------------------------------------------
    // Request selection
    // ------------------------------------------------------------------
    always_comb
    begin
        req = '0;
        req[3:0] = irq_flag_one[3:0] & system_control_two[3:0];
        req[SRC_DT] = irq_flag_one[DT_FLAG_BIT];
        req[SRC_RTC] = irq_flag_one[RTC_BIT] & system_control_two[RTC_BIT];
        req[SRC_TMR] = timer_ovf_irq;
        // All four serial three events share one vector.
        req[SRC_SCI] = sci3_rx_full | sci3_tx_empty
                     | sci3_tx_end | sci3_rx_err;
    end

    iefl_prio u_prio (
        .req        (req),
        .any_req    (any_req),
        .win_vec    (win_vec),
        .win_onehot (win_onehot)
    );

    assign win_ext = |(win_onehot & EXT_SRC_MASK);

    // ------------------------------------------------------------------
    // Exception sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:
                if (any_req && !mask_bit)
                    next_state = S_PRIO;
            S_PRIO:
                if (mask_bit)
                    next_state = S_IDLE;
                else if (expired)
                    next_state = S_WAIT;
            S_WAIT:
                if (insn_done)
                    next_state = S_PUSH;
            S_PUSH:
                if (expired)
                    next_state = S_VFETCH;
            S_VFETCH:
                if (expired)
                    next_state = S_IFETCH;
            S_IFETCH:
                if (expired)
                    next_state = S_INTERN;
            S_INTERN:
                if (expired)
                    next_state = S_IDLE;
        endcase
    end

    // A step is timed from the edge that enters it.
    assign seq_load = (next_state != state) && (next_state != S_IDLE)
                      && (next_state != S_WAIT);
    assign seq_count = (next_state != S_PRIO) ? PHASE_STATES
                     : (win_ext ? PRIO_EXT_STATES
                                : PRIO_INT_STATES);

    iefl_seq u_seq (
        .core_clk (core_clk),
        .nrst     (nrst),
        .load     (seq_load),
        .count    (seq_count),
        .expired  (expired)
    );

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // Once chosen, the vector is kept even if its flag or enable is
    // cleared meanwhile; the CPU takes it after the clearing instruction.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vector_no <= VEC_NONE;
            ext_lat   <= 1'b0;
        end
        else if (state == S_IDLE && next_state == S_PRIO)
        begin
            vector_no <= win_vec;
            ext_lat   <= win_ext;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exc_start     <= 1'b0;
            stack_push    <= 1'b0;
            vector_fetch  <= 1'b0;
            handler_fetch <= 1'b0;
            internal_proc <= 1'b0;
            exc_done      <= 1'b0;
        end
        else
        begin
            exc_start     <= (state == S_WAIT) && insn_done;
            stack_push    <= (next_state == S_PUSH);
            vector_fetch  <= (next_state == S_VFETCH);
            handler_fetch <= (next_state == S_IFETCH);
            internal_proc <= (next_state == S_INTERN);
            exc_done      <= (state == S_INTERN) && expired;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    tmr_en_write_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        wr_en2 |=> timer_ovf_irq
                   == (timer_ovf_req && $past(wdat[TMR_EN_BIT])))
        else $error("timer enable write not applied");

    en2_high_zero_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (avs_read && ack && hit(avs_address, ADDR_ENABLE_TWO))
        |-> avs_readdata[7:6] == 2'b00)
        else $error("enable register top bits not zero");

    en2_low_ones_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (avs_read && ack && hit(avs_address, ADDR_ENABLE_TWO))
        |-> avs_readdata[4:0] == 5'h1f)
        else $error("enable register low bits not one");

    dt_flag_set_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        sleep_direct && system_control_two[DT_ON_BIT]
        |=> irq_flag_one[DT_FLAG_BIT])
        else $error("direct transition flag not set");

    dt_flag_hold_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        irq_flag_one[DT_FLAG_BIT] && !(wr_flag && !wdat[DT_FLAG_BIT])
        |=> irq_flag_one[DT_FLAG_BIT])
        else $error("direct transition flag lost without clear");

    prio_ext_len_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (state == S_IDLE && next_state == S_PRIO && win_ext)
        ##1 !mask_bit [*2]
        |=> $past(state) == S_PRIO && state == S_WAIT)
        else $error("external priority step not two states");

    prio_int_len_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (state == S_IDLE && next_state == S_PRIO && !win_ext)
        ##1 !mask_bit |=> state == S_WAIT)
        else $error("internal priority step not one state");

    push_len_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(stack_push) |-> stack_push [*4] ##1
        (vector_fetch && !stack_push) [*4] ##1 handler_fetch)
        else $error("push or vector step not four states");

    wait_insn_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state == S_WAIT && !insn_done |=> state == S_WAIT
        && $stable(vector_no))
        else $error("sequence left wait before instruction end");

    vec_legal_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state == S_PRIO |-> vector_no != VEC_RESERVED
        && (!$past(req == 8'h80) || !$past(state == S_IDLE)
            || vector_no == SRC_VEC[SRC_SCI]))
        else $error("serial three vector wrong or reserved used");

    mask_block_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state == S_IDLE && mask_bit |=> state == S_IDLE)
        else $error("masked request started a sequence");

    seq_run_c: cover property (
        @(posedge core_clk) disable iff (!nrst)
        exc_start ##[1:40] exc_done);

    ext_prio_c: cover property (
        @(posedge core_clk) disable iff (!nrst)
        state == S_PRIO && ext_lat ##1 state == S_PRIO);

    clr_collide_c: cover property (
        @(posedge core_clk) disable iff (!nrst)
        state == S_WAIT && (wr_flag || wr_en2) && !mask_bit);

    dt_set_c: cover property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(irq_flag_one[DT_FLAG_BIT]));

endmodule : iefl_top

//--- iefl_cpu_model.sv
// Behavioural CPU core model that paces instruction completion.
`timescale 1ns/1ns
module iefl_cpu_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Instruction length in states
    input  wire logic [4:0] insn_len,
    // To the interrupt block
    output logic            insn_done
);
    // ------------------------------------------------------------------
    // Instruction pacing
    // ------------------------------------------------------------------
    logic [4:0] state_cnt;

    // Every instruction lasts insn_len states, one to twenty-three.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            state_cnt <= 5'h01;
        else if (state_cnt >= insn_len)
            state_cnt <= 5'h01;
        else
            state_cnt <= state_cnt + 5'h01;
    end

    // A length of one keeps this high, so every state ends an instruction.
    assign insn_done = (state_cnt >= insn_len);
endmodule : iefl_cpu_model

//--- iefl_top_bench.sv
// Self-checking bench for the interrupt enable and flag logic.
`timescale 1ns/1ns
module iefl_top_bench;
    import iefl_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        core_clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address, insn_len;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable, external_irq_pins, sci;
    logic        timer_ovf_req, rtc_evt, sleep_direct, mask_bit;
    logic        insn_done, timer_ovf_irq, exc_start, stack_push;
    logic        vector_fetch, handler_fetch, internal_proc, exc_done;
    logic [5:0]  vector_no;
    logic [7:0]  d;
    int          failures, compares, en_m, fl_m, sy_m, n, vec_m;

    iefl_top u_dut (
        .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer_ovf_req(timer_ovf_req), .rtc_evt(rtc_evt),
        .external_irq_pins(external_irq_pins), .sci3_rx_full(sci[0]),
        .sci3_tx_empty(sci[1]), .sci3_tx_end(sci[2]),
        .sci3_rx_err(sci[3]), .sleep_direct(sleep_direct),
        .mask_bit(mask_bit), .insn_done(insn_done),
        .timer_ovf_irq(timer_ovf_irq), .exc_start(exc_start),
        .stack_push(stack_push), .vector_fetch(vector_fetch),
        .handler_fetch(handler_fetch), .internal_proc(internal_proc),
        .exc_done(exc_done), .vector_no(vector_no));

    iefl_cpu_model u_cpu (
        .core_clk(core_clk), .nrst(nrst), .insn_len(insn_len),
        .insn_done(insn_done));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic give_verdict;
        begin
            if (failures == 0 && compares > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        begin
            compares++;
            if (got !== exp)
            begin
                failures++;
                $display("[FAIL] t=%0t got %h want %h", $time, got, exp);
            end
        end
    endtask : check

    task automatic stop_hung;
        begin
            failures++;
            $display("[FAIL] t=%0t wait ran out", $time);
            give_verdict();
        end
    endtask : stop_hung

    // Holds the request until waitrequest is seen low, then idles a cycle
    // so that back-to-back calls never drive a strobe twice in one step.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] dat, input logic [3:0] be);
        begin
            avs_address <= a;
            avs_writedata <= {24'h0, dat};
            avs_byteenable <= be;
            avs_write <= wr;
            avs_read <= ~wr;
            n = 0;
            do
            begin
                @(posedge core_clk);
                n++;
            end
            while (avs_waitrequest !== 1'b0 && n < 20);
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge core_clk);
            if (n >= 20)
                stop_hung();
        end
    endtask : bus

    function automatic logic [31:0] exp_rd(input logic [4:0] a);
        begin
            case (a)
                ADDR_ENABLE_TWO: exp_rd = EN2_ONES | en_m;
                ADDR_FLAG_ONE:   exp_rd = fl_m & FLAG_MASK;
                ADDR_SYS_CTRL:   exp_rd = sy_m & SYSC_MASK;
                ADDR_STATUS:     exp_rd = vec_m << STAT_VEC_LSB;
                default:         exp_rd = 32'h0;
            endcase
        end
    endfunction : exp_rd

    task automatic wr(input logic [4:0] a, input logic [7:0] dat,
                      input logic [3:0] be);
        begin
            bus(1'b1, a, dat, be);
            if (be[0] && a == ADDR_ENABLE_TWO)
                en_m = dat & (1 << TMR_EN_BIT);
            if (be[0] && a == ADDR_FLAG_ONE)
                fl_m = fl_m & dat;
            if (be[0] && a == ADDR_SYS_CTRL)
                sy_m = dat;
        end
    endtask : wr

    task automatic rd(input logic [4:0] a);
        begin
            bus(1'b0, a, 8'h00, 4'hf);
            check(q, exp_rd(a));
        end
    endtask : rd

    task automatic pulse(input logic dt, input logic rt,
                         input logic [3:0] p);
        begin
            sleep_direct <= dt;
            rtc_evt <= rt;
            external_irq_pins <= p;
            @(posedge core_clk);
            sleep_direct <= 1'b0;
            rtc_evt <= 1'b0;
            external_irq_pins <= 4'h0;
            @(posedge core_clk);
            if (dt && sy_m[DT_ON_BIT])
                fl_m |= 8'h80;
            if (rt)
                fl_m |= 8'h40;
            fl_m |= p;
        end
    endtask : pulse

    // Unmasks, then follows one exception sequence cycle by cycle; the
    // handler masks again as soon as the sequence starts.
    task automatic take(input logic [5:0] v, input int pr);
        int         k;
        int         j;
        logic       ins [0:63];
        logic [5:0] exp;
        begin
            mask_bit <= 1'b0;
            k = -1;
            do
            begin
                @(posedge core_clk);
                k++;
                ins[k] = insn_done;
            end
            while (exc_start !== 1'b1 && k < 60);
            if (k >= 60)
                stop_hung();
            mask_bit <= 1'b1;
            check(vector_no, v);
            vec_m = v;
            check(k >= pr + 2, 1'b1);
            check(ins[k-1], 1'b1);
            for (j = pr + 1; j < k - 1; j++)
                check(ins[j], 1'b0);
            for (j = 0; j <= 16; j++)
            begin
                if (j > 0)
                    @(posedge core_clk);
                exp = (j < 16) ? (6'h10 >> (j / 4)) : 6'h01;
                exp[5] = (j == 0);
                check({exc_start, stack_push, vector_fetch, handler_fetch,
                       internal_proc, exc_done}, exp);
            end
            @(posedge core_clk);
        end
    endtask : take

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {avs_read, avs_write, timer_ovf_req, rtc_evt, sleep_direct} = 5'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        external_irq_pins = 4'h0;
        sci = 4'h0;
        mask_bit = 1'b1;
        insn_len = 5'h01;
        nrst = 1'b0;
        {failures, compares, en_m, fl_m, sy_m} = 0;
        vec_m = VEC_NONE;
        void'($urandom(32'hb60091af));
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(ADDR_ENABLE_TWO);
        rd(ADDR_FLAG_ONE);
        rd(5'h10);
        rd(ADDR_STATUS);
        timer_ovf_req <= 1'b1;
        @(posedge core_clk);
        check(timer_ovf_irq, 1'b0);
        repeat (6)
        begin
            d = 8'($urandom);
            wr(ADDR_ENABLE_TWO, d, ($urandom & 1) ? 4'hf : 4'he);
            rd(ADDR_ENABLE_TWO);
            check(timer_ovf_irq, en_m[TMR_EN_BIT]);
        end
        wr(ADDR_ENABLE_TWO, 8'h00, 4'hf);
        pulse(1'b1, 1'b0, 4'h0);
        rd(ADDR_FLAG_ONE);
        wr(ADDR_SYS_CTRL, 8'h8f, 4'hf);
        rd(ADDR_SYS_CTRL);
        pulse(1'b1, 1'b1, 4'h5);
        rd(ADDR_FLAG_ONE);
        wr(ADDR_FLAG_ONE, 8'hff, 4'hf);
        rd(ADDR_FLAG_ONE);
        wr(ADDR_FLAG_ONE, 8'h7f, 4'hf);
        rd(ADDR_FLAG_ONE);
        wr(ADDR_FLAG_ONE, 8'h00, 4'hf);
        rd(ADDR_FLAG_ONE);
        wr(ADDR_ENABLE_TWO, 8'h20, 4'hf);
        repeat (20)
        begin
            @(posedge core_clk);
            check(exc_start, 1'b0);
        end
        insn_len <= 5'($urandom_range(23, 1));
        take(SRC_VEC[SRC_TMR], 1);
        sci <= 4'h1 << $urandom_range(3, 0);
        pulse(1'b1, 1'b0, 4'h1);
        take(SRC_VEC[SRC_DT], 1);
        wr(ADDR_FLAG_ONE, 8'h7f, 4'hf);
        take(SRC_VEC[0], 2);
        wr(ADDR_FLAG_ONE, 8'h00, 4'hf);
        take(SRC_VEC[SRC_TMR], 1);
        wr(ADDR_ENABLE_TWO, 8'h00, 4'hf);
        take(6'h22, 1);
        sci <= 4'h0;
        wr(ADDR_ENABLE_TWO, 8'h20, 4'hf);
        insn_len <= 5'd23;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (insn_done !== 1'b1 && n < 40);
        fork
            take(SRC_VEC[SRC_TMR], 1);
            begin
                repeat (3) @(posedge core_clk);
                wr(ADDR_ENABLE_TWO, 8'h00, 4'hf);
            end
        join
        timer_ovf_req <= 1'b0;
        rd(ADDR_ENABLE_TWO);
        rd(ADDR_STATUS);
        give_verdict();
    end
endmodule : iefl_top_bench
